// ---- hw/sar_adc_defines.svh ----
// Register map, field positions and timing constants of the converter control block.
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// ------------------------------------------------------------
// Register indices; the byte address is four times the index
// ------------------------------------------------------------
`define CTRL_INDEX 6'h0E
`define RESULT_INDEX 6'h0F
`define CTRL_RESET 8'h00
`define ADC_INVALID 8'hFF

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define F_CHAN_MSB 3
`define F_CHAN_TOP 3
`define F_DISABLE 4
`define F_SPEED 5
`define F_GO 6
`define F_DONE 7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ 20
`define MC_NS 500
`define MC_CLKS ((`MC_NS * `CLK_MHZ) / 1000)
`define CONV_SHORT_NS 23000
`define CONV_LONG_NS 92000
`define CONV_SHORT_MC (`CONV_SHORT_NS / `MC_NS)
`define CONV_LONG_MC (`CONV_LONG_NS / `MC_NS)
`define SAMPLE_MC 4
`define SAR_FIRST 8'h80

`endif

// ---- hw/sar_adc_pkg.sv ----
// Types shared by the converter control block.
package sar_adc_pkg;

  // ------------------------------------------------------------
  // Conversion sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } conv_state_t;

endpackage

// ---- hw/sar_step.sv ----
// Successive-approximation register that builds the 8-bit code one bit per step.
`timescale 1ns/1ps
`include "sar_adc_defines.svh"

module sar_step #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic step,
  input wire logic comp_high,
  output logic [WIDTH-1:0] code_r,
  output logic settled_r
);

  logic [WIDTH-1:0] mask_r;

  // ------------------------------------------------------------
  // Trial bit walk
  // ------------------------------------------------------------
  // Each step keeps the trial bit if the input is at or above the ladder level.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      code_r <= '0;
      mask_r <= '0;
      settled_r <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        code_r <= WIDTH'(`SAR_FIRST);
        mask_r <= WIDTH'(`SAR_FIRST);
        settled_r <= 1'b0;
      end else if (step && !settled_r) begin
        code_r <= (comp_high ? code_r : (code_r & ~mask_r)) | (mask_r >> 1);
        mask_r <= mask_r >> 1;
        settled_r <= mask_r[0];
      end
    end
  end

endmodule

// ---- hw/sar_adc_control.sv ----
// Sequencer and Wishbone register slave of the 8-channel 8-bit SAR converter.
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
// Overview of operation
// - Channel codes 0 to 7 route inputs 0 to 7; codes with top bit are reserved.
// - Bit 4 low enables analog inputs, high disables them; it is low after reset.
// - Short conversion lasts 46 machine cycles from start to result written.
// - Speed bit set selects the long conversion, four times the short one.
// - Writing 1 to bit 6 starts a conversion; writing 0 does nothing.
// - The start bit returns to 0 by itself once conversion begins.
// - Start during a conversion abandons it and starts over.
// - The selected input is sampled every 4 machine cycles.
// - Done flag, bit 7, sets at completion and reads 0 before and during.
// - Reading the result register clears the done flag.
// - The done flag is read-only to software.
// - Result read during conversion returns an invalid value.
// - Stop mode during conversion ends it; done flag stays 0.
// - Stop mode after completion keeps the result unchanged.
// - Control register resets to all zeros.
// - Each result is an 8-bit code from ladder comparisons.

module sar_adc_control #(
  parameter int MC_CLKS = `MC_CLKS,
  parameter int SHORT_MC = `CONV_SHORT_MC,
  parameter int LONG_MC = `CONV_LONG_MC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stop_req,
  input wire logic comp_high,
  output logic [2:0] chan_sel_r,
  output logic mux_en_r,
  output logic [7:0] ladder_code_r,
  output logic sample_r,
  output logic busy_r
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  sar_adc_pkg::conv_state_t state_r;
  logic [7:0] ctrl_r;
  logic [7:0] result_r;
  logic go_r;
  logic done_r;
  logic [3:0] mc_div_r;
  logic [7:0] conv_cnt_r;
  logic mc_tick;
  logic sample_now;
  logic fin;
  logic req;
  logic wr_ctrl;
  logic rd_res;
  logic [7:0] total_mc;
  logic [7:0] sar_code;
  logic sar_settled;

  // Address decode shared by the write and read paths.
  function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
    hit = (a == idx);
  endfunction

  // ------------------------------------------------------------
  // Bus request qualification
  // ------------------------------------------------------------
  // A request is taken once, in the cycle before ack rises.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i[7:2], `CTRL_INDEX);
  assign rd_res = req && !wb_we_i && hit(wb_adr_i[7:2], `RESULT_INDEX);

  // ------------------------------------------------------------
  // Timing decode
  // ------------------------------------------------------------
  assign total_mc = ctrl_r[`F_SPEED] ? 8'(LONG_MC) : 8'(SHORT_MC);
  assign mc_tick = (mc_div_r == 4'(MC_CLKS - 1));
  assign sample_now = busy_r && mc_tick
    && (conv_cnt_r[1:0] == 2'(`SAMPLE_MC - 1));
  assign fin = busy_r && mc_tick && (conv_cnt_r == total_mc - 8'h01) && !go_r;

  // ------------------------------------------------------------
  // Wishbone acknowledge
  // ------------------------------------------------------------
  // One wait state; ack falls the cycle after it was given.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Unmapped addresses read as zero; the result reads invalid while busy.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      if (req && !wb_we_i && hit(wb_adr_i[7:2], `CTRL_INDEX)) begin
        wb_dat_o <= {24'h000000, done_r, go_r, ctrl_r[5:0]};
      end else if (rd_res) begin
        wb_dat_o <= {24'h000000, busy_r ? `ADC_INVALID : result_r};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Channel, input disable and speed are plain storage; the mux enable
  // is registered beside them so the pin outputs come from flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RESET;
      mux_en_r <= 1'b1;
      chan_sel_r <= 3'h0;
    end else if (ce && wr_ctrl) begin
      ctrl_r <= {2'b00, wb_dat_i[5:0]};
      chan_sel_r <= wb_dat_i[2:0];
      mux_en_r <= !wb_dat_i[`F_CHAN_TOP] && !wb_dat_i[`F_DISABLE];
    end
  end

  // ------------------------------------------------------------
  // Start bit
  // ------------------------------------------------------------
  // Held for exactly one cycle, so software sees it clear itself.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      go_r <= 1'b0;
    end else if (ce) begin
      go_r <= wr_ctrl && wb_dat_i[`F_GO];
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // A start while busy lands here too and simply restarts the count.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= sar_adc_pkg::ST_IDLE;
    end else if (ce) begin
      case (state_r)
        sar_adc_pkg::ST_IDLE: begin
          if (go_r && !stop_req) begin
            state_r <= sar_adc_pkg::ST_CONV;
          end
        end
        sar_adc_pkg::ST_CONV: begin
          if (stop_req || fin) begin
            state_r <= sar_adc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= sar_adc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Busy mirrors the next state so it is a clean flop output.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      if (stop_req) begin
        busy_r <= 1'b0;
      end else if (go_r) begin
        busy_r <= 1'b1;
      end else if (fin) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Machine-cycle divider and conversion counter
  // ------------------------------------------------------------
  // Both restart on every start so a restart begins from scratch.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mc_div_r <= 4'h0;
      conv_cnt_r <= 8'h00;
    end else if (ce) begin
      if (go_r || !busy_r) begin
        mc_div_r <= 4'h0;
        conv_cnt_r <= 8'h00;
      end else if (mc_tick) begin
        mc_div_r <= 4'h0;
        conv_cnt_r <= conv_cnt_r + 8'h01;
      end else begin
        mc_div_r <= mc_div_r + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Sample strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_r <= 1'b0;
    end else if (ce) begin
      sample_r <= sample_now && !stop_req;
    end
  end

  // ------------------------------------------------------------
  // Approximation register
  // ------------------------------------------------------------
  // Eight of the samples decide the bits; later samples leave the code.
  sar_step #(
    .WIDTH(8)
  ) u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clear(go_r),
    .step(sample_now),
    .comp_high(comp_high),
    .code_r(sar_code),
    .settled_r(sar_settled)
  );

  // The ladder follows the trial code one cycle later.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ladder_code_r <= 8'h00;
    end else if (ce) begin
      ladder_code_r <= sar_code;
    end
  end

  // ------------------------------------------------------------
  // Result register
  // ------------------------------------------------------------
  // Written only at completion, so a stop after completion keeps it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_r <= 8'h00;
    end else if (ce && fin && !stop_req) begin
      result_r <= sar_code;
    end
  end

  // ------------------------------------------------------------
  // Done flag
  // ------------------------------------------------------------
  // Completion beats a result read in the same cycle; a start or a stop
  // before completion keeps it low. Software writes never reach it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
    end else if (ce) begin
      if (fin && !stop_req) begin
        done_r <= 1'b1;
      end else if (go_r || rd_res) begin
        done_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Counts enabled cycles since the last start, to time the conversion.
  // The completion cycle is the last one counted, so it sits one below the total.
  logic [15:0] elapsed_r;
  always_ff @(posedge clk) begin
    if (sys_rst || go_r) begin
      elapsed_r <= 16'h0000;
    end else if (ce) begin
      elapsed_r <= elapsed_r + 16'h0001;
    end
  end

  sequence s_start;
    ce && go_r && !stop_req;
  endsequence

  sequence s_running;
    busy_r && (conv_cnt_r == 8'h00) && (mc_div_r == 4'h0);
  endsequence

  property p_go_self_clear;
    @(posedge clk) disable iff (sys_rst)
      ce && go_r && !wr_ctrl |=> !go_r;
  endproperty
  a_go_self_clear: assert property (p_go_self_clear)
    else $error("start bit did not clear itself");

  property p_start_runs;
    @(posedge clk) disable iff (sys_rst)
      s_start |=> s_running;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not begin a fresh conversion");

  property p_done_low_busy;
    @(posedge clk) disable iff (sys_rst)
      busy_r |-> !done_r;
  endproperty
  a_done_low_busy: assert property (p_done_low_busy)
    else $error("done flag high during conversion");

  property p_result_with_flag;
    @(posedge clk) disable iff (sys_rst)
      $rose(done_r) |-> result_r == $past(sar_code) && $past(fin) && $past(sar_settled);
  endproperty
  a_result_with_flag: assert property (p_result_with_flag)
    else $error("done flag rose without result or completion");

  property p_read_clears;
    @(posedge clk) disable iff (sys_rst)
      ce && rd_res && !fin |=> !done_r;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("result read did not clear done flag");

  property p_stop_aborts;
    @(posedge clk) disable iff (sys_rst)
      ce && stop_req && busy_r |=> !busy_r && !done_r;
  endproperty
  a_stop_aborts: assert property (p_stop_aborts)
    else $error("stop did not abort conversion");

  property p_stop_holds;
    @(posedge clk) disable iff (sys_rst)
      stop_req && done_r |=> $stable(result_r);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("result changed in stop mode");

  property p_conv_time;
    @(posedge clk) disable iff (sys_rst)
      ce && fin |-> elapsed_r == 16'(32'(total_mc) * MC_CLKS - 1);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("conversion length wrong");

  property p_mux_gate;
    @(posedge clk) disable iff (sys_rst)
      mux_en_r |-> !ctrl_r[`F_CHAN_TOP] && !ctrl_r[`F_DISABLE];
  endproperty
  a_mux_gate: assert property (p_mux_gate)
    else $error("mux enabled for reserved code or disabled input");

  property p_sample_phase;
    @(posedge clk) disable iff (sys_rst)
      ce && sample_r |-> conv_cnt_r[1:0] == 2'b00 && mc_div_r == 4'h0;
  endproperty
  a_sample_phase: assert property (p_sample_phase)
    else $error("sample strobe off its four-cycle phase");

  property p_reset_zero;
    @(posedge clk) sys_rst |=> ctrl_r == `CTRL_RESET && !done_r && !go_r;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("control register not zero after reset");

endmodule

// ---- testbench/analog_source.sv ----
// Behavioural model of the analog sources and comparator at the converter's inputs.
`timescale 1ns/1ps

module analog_source #(
  parameter logic [7:0] LEVEL [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}
) (
  input wire logic [2:0] chan_sel_r,
  input wire logic mux_en_r,
  input wire logic [7:0] ladder_code_r,
  output logic comp_high
);
  // ------------------------------------------------------------
  // Comparator
  // ------------------------------------------------------------
  // An input that is not routed gives no signal, so the comparator stays low.
  assign comp_high = mux_en_r && (LEVEL[chan_sel_r] >= ladder_code_r);
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the converter control block over its Wishbone registers.
`timescale 1ns/1ps

module testbench;
  localparam int MCK = 2;
  localparam int SHORT = 36;
  localparam int LONG = 40;
  localparam logic [7:0] CTRL_A = 8'h38;
  localparam logic [7:0] RES_A = 8'h3C;
  localparam logic [7:0] NONE_A = 8'h40;
  localparam logic [7:0] LVL [8] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h55, 8'hAA, 8'h01, 8'hC3};
  logic clk, sys_rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stop_req, comp_high;
  logic mux_en_r, sample_r, busy_r;
  logic [7:0] wb_adr_i, ladder_code_r, rd;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0] chan_sel_r;
  int err_total, num_checks, busy_cnt, samp_cnt, cyc_cnt, tot;

  sar_adc_control #(.MC_CLKS(MCK), .SHORT_MC(SHORT), .LONG_MC(LONG)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_req(stop_req), .comp_high(comp_high),
    .chan_sel_r(chan_sel_r), .mux_en_r(mux_en_r), .ladder_code_r(ladder_code_r),
    .sample_r(sample_r), .busy_r(busy_r));

  analog_source #(.LEVEL(LVL)) i_src (
    .chan_sel_r(chan_sel_r), .mux_en_r(mux_en_r), .ladder_code_r(ladder_code_r),
    .comp_high(comp_high));

  // ------------------------------------------------------------
  // Clock, cycle ceiling and activity counters
  // ------------------------------------------------------------
  // The ceiling leaves wide margin over the thousand or so cycles the tests need.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (busy_r === 1'b1) busy_cnt++;
    if (sample_r === 1'b1) samp_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Compare tasks and verdict
  // ------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkn(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Bus access
  // ------------------------------------------------------------
  // The request is held until ack is sampled high, then released for one cycle.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, wd};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      xfer(1'b0, CTRL_A, 8'h00);
      if (rd[7] === 1'b1) break;
    end
  endtask
  task automatic pulse_stop();
    @(posedge clk);
    stop_req <= 1'b1;
    repeat (3) @(posedge clk);
    stop_req <= 1'b0;
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, stop_req, sys_rst} = 5'b00001;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'h1;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b0, CTRL_A, 8'h00);
    chk8("control after reset", 8'h00, rd);
    chk8("mux enable after reset", 8'h01, {7'h00, mux_en_r});
    xfer(1'b0, NONE_A, 8'h00);
    chk8("unmapped read", 8'h00, rd);
    for (int ch = 0; ch < 8; ch++) begin
      tot = (ch == 7) ? LONG : SHORT;
      xfer(1'b1, CTRL_A, {2'b00, ch == 7, 2'b00, ch[2:0]});
      chk8("channel routed", {4'h0, 1'b1, ch[2:0]}, {4'h0, mux_en_r, chan_sel_r});
      chk8("idle after go zero", 8'h00, {7'h00, busy_r});
      busy_cnt = 0;
      samp_cnt = 0;
      xfer(1'b1, CTRL_A, {2'b01, ch == 7, 2'b00, ch[2:0]});
      xfer(1'b0, CTRL_A, 8'h00);
      chk8("control during run", {3'b001 & {2'b00, ch == 7}, 2'b00, ch[2:0]}, rd);
      xfer(1'b0, RES_A, 8'h00);
      chk8("result during run", 8'hFF, rd);
      wait_done();
      chkn("busy cycles", tot * MCK, busy_cnt);
      chkn("sample pulses", tot / 4, samp_cnt);
      chk8("done flag", {3'b101 & {2'b10, ch == 7}, 2'b00, ch[2:0]}, rd);
      xfer(1'b1, CTRL_A, {2'b00, ch == 7, 2'b00, ch[2:0]});
      xfer(1'b0, CTRL_A, 8'h00);
      chk8("done after write", {3'b101 & {2'b10, ch == 7}, 2'b00, ch[2:0]}, rd);
      xfer(1'b0, RES_A, 8'h00);
      chk8("result", LVL[ch], rd);
      xfer(1'b0, CTRL_A, 8'h00);
      chk8("done cleared", {2'b00, ch == 7, 2'b00, ch[2:0]}, rd);
    end
    xfer(1'b1, CTRL_A, 8'h80);
    xfer(1'b0, CTRL_A, 8'h00);
    chk8("done write at idle", 8'h00, rd);
    xfer(1'b1, CTRL_A, 8'h12);
    chk8("input disabled", 8'h00, {7'h00, mux_en_r});
    xfer(1'b1, CTRL_A, 8'h08);
    chk8("reserved channel", 8'h00, {7'h00, mux_en_r});
    xfer(1'b1, CTRL_A, 8'h04);
    xfer(1'b1, CTRL_A, 8'h44);
    repeat (10) @(posedge clk);
    xfer(1'b1, CTRL_A, 8'h44);
    repeat (20) @(posedge clk);
    xfer(1'b0, CTRL_A, 8'h00);
    chk8("restarted still running", 8'h05, {rd[7:1], busy_r});
    wait_done();
    xfer(1'b0, RES_A, 8'h00);
    chk8("result after restart", LVL[4], rd);
    xfer(1'b1, CTRL_A, 8'h43);
    repeat (6) @(posedge clk);
    pulse_stop();
    chk8("stopped mid run", 8'h00, {7'h00, busy_r});
    xfer(1'b0, CTRL_A, 8'h00);
    chk8("done after stop", 8'h03, rd);
    xfer(1'b1, CTRL_A, 8'h45);
    wait_done();
    pulse_stop();
    xfer(1'b0, RES_A, 8'h00);
    chk8("result kept over stop", LVL[5], rd);
    results();
  end
endmodule
